// [include/lfs_defs.vh]
`ifndef LFS_DEFS_VH
`define LFS_DEFS_VH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define LFS_IDX_LINK_STAT   6'h14
`define LFS_IDX_RSVD_A      6'h15
`define LFS_IDX_RSVD_B      6'h16
`define LFS_IDX_RSVD_C      6'h17
`define LFS_IDX_RSVD_D      6'h18
`define LFS_IDX_RSVD_E      6'h19
`define LFS_IDX_RSVD_F      6'h1a
`define LFS_IDX_RSVD_G      6'h1b
`define LFS_IDX_RSVD_H      6'h1c
`define LFS_IDX_PIN_LEVELS  6'h1d
`define LFS_IDX_DEV_ID      6'h1e
`define LFS_IDX_CAP_REV     6'h1f
`define LFS_IDX_IRQ_STAT    6'h20
`define LFS_IDX_IRQ_MASK    6'h21

// ----------------------------------------
// reset and fixed contents
// ----------------------------------------
`define LFS_RST_RSVD_A      8'h20
`define LFS_RST_RSVD_B      8'h30
`define LFS_RST_RSVD_C      8'h54
`define LFS_RST_RSVD_D      8'h30
`define LFS_RST_RSVD_E      8'hc8
`define LFS_RST_RSVD_F      8'h00
`define LFS_RST_RSVD_G      8'h00
`define LFS_RST_RSVD_H      8'h00
`define LFS_RST_PRBS        1'h0
`define LFS_RST_IRQ         3'h0

// ----------------------------------------
// wire fault codes
// ----------------------------------------
`define LFS_FAULT_SUPPLY    2'h0
`define LFS_FAULT_GROUND    2'h1
`define LFS_FAULT_NORMAL    2'h2
`define LFS_FAULT_OPEN      2'h3

// ----------------------------------------
// field positions
// ----------------------------------------
`define LFS_PRBS_BIT        7
`define LFS_NEG_HI          3
`define LFS_NEG_LO          2
`define LFS_POS_HI          1
`define LFS_POS_LO          0
`define LFS_CAP_BIT         4
`define LFS_EV_PRBS         0
`define LFS_EV_FAULT        1
`define LFS_EV_PINS         2
`define LFS_NUM_EV          3
`define LFS_NUM_PINS        4

`endif

// [core/lfs_pin_sync.v]
`timescale 1ns/1ps
// three-stage sampler; level changes only when stages two and three agree
module lfs_pin_sync #(
    parameter WIDTH = 4
) (
    input  wire             sys_clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] level_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg s1_r;
            reg s2_r;
            reg s3_r;
            reg lvl_r;
            always @(posedge sys_clk) begin
                if (rst) begin
                    s1_r  <= 1'h0;
                    s2_r  <= 1'h0;
                    s3_r  <= 1'h0;
                    lvl_r <= 1'h0;
                end else begin
                    s1_r <= pin_in[i];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    // filters a single-cycle glitch after metastability
                    if (s2_r == s3_r) begin
                        lvl_r <= s3_r;
                    end
                end
            end
            assign level_out[i] = lvl_r;
        end
    endgenerate
endmodule

// [core/lfs_irq.v]
`timescale 1ns/1ps
`include "lfs_defs.vh"
// sticky event bits, write-one-to-clear, set wins over clear
module lfs_irq (
    input  wire                    sys_clk,
    input  wire                    rst,
    input  wire [`LFS_NUM_EV-1:0]  event_in,
    input  wire [`LFS_NUM_EV-1:0]  clear_in,
    input  wire [`LFS_NUM_EV-1:0]  mask_in,
    output wire [`LFS_NUM_EV-1:0]  status_out,
    output wire                    irq_out
);
    reg  [`LFS_NUM_EV-1:0] status_r;
    wire [`LFS_NUM_EV-1:0] status_nxt;

    assign status_nxt = (status_r & ~clear_in) | event_in;

    always @(posedge sys_clk) begin
        if (rst) begin
            status_r <= `LFS_RST_IRQ;
        end else begin
            status_r <= status_nxt;
        end
    end

    assign status_out = status_r;
    assign irq_out    = |(status_r & mask_in);
endmodule

// [core/lfs_status_regs.v]
`timescale 1ns/1ps
`include "lfs_defs.vh"
// Notes on behaviour
// - bit 7 of link status reads 1 only after prbs test passed, else 0
// - negative wire fault code in bits 3:2, normal 10 after reset
// - positive wire fault code in bits 1:0, normal 10 after reset
// - fixed 8-bit device identifier, read only, writes ignored
module lfs_status_regs #(
    parameter [7:0] DEV_ID   = 8'h5a, // arbitrary value
    parameter [3:0] REVISION = 4'h1,  // arbitrary value
    parameter       CAP_FLAG = 1'b0
) (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire        wb_ack_o,
    input  wire        prbs_done_ok,
    input  wire [1:0]  neg_wire_fault_code,
    input  wire [1:0]  pos_wire_fault_code,
    input  wire        cable_type_pin_level,
    input  wire        coax_input_select_level,
    input  wire        control_iface_select_level,
    input  wire        local_ctrl_channel_enable_level,
    output wire        irq
);
    // ----------------------------------------
    // status capture
    // ----------------------------------------
    reg        prbs_pass_flag_r;
    reg  [1:0] neg_fault_r;
    reg  [1:0] pos_fault_r;
    wire [3:0] pin_lvl;
    reg  [3:0] pin_lvl_d_r;

    lfs_pin_sync #(
        .WIDTH (`LFS_NUM_PINS)
    ) u_sync (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .pin_in    ({cable_type_pin_level, coax_input_select_level,
                     control_iface_select_level, local_ctrl_channel_enable_level}),
        .level_out (pin_lvl)
    );

    always @(posedge sys_clk) begin
        if (rst) begin
            prbs_pass_flag_r <= `LFS_RST_PRBS;
            neg_fault_r      <= `LFS_FAULT_NORMAL;
            pos_fault_r      <= `LFS_FAULT_NORMAL;
            pin_lvl_d_r      <= 4'h0;
        end else begin
            prbs_pass_flag_r <= prbs_done_ok;
            neg_fault_r      <= neg_wire_fault_code;
            pos_fault_r      <= pos_wire_fault_code;
            pin_lvl_d_r      <= pin_lvl;
        end
    end

    // ----------------------------------------
    // events and interrupt
    // ----------------------------------------
    wire [2:0] ev;
    wire [2:0] ev_clr;
    wire [2:0] ev_stat;
    reg  [2:0] irq_mask_r;

    assign ev[`LFS_EV_PRBS]  = prbs_done_ok & ~prbs_pass_flag_r;
    assign ev[`LFS_EV_FAULT] = (neg_wire_fault_code != neg_fault_r) |
                               (pos_wire_fault_code != pos_fault_r);
    assign ev[`LFS_EV_PINS]  = pin_lvl != pin_lvl_d_r;

    // ----------------------------------------
    // wishbone slave
    // ----------------------------------------
    reg        ack_r;
    reg  [7:0] rdata_r;
    reg  [7:0] rdata_nxt;
    wire [5:0] idx;
    wire       req;
    wire       wr_lo;

    assign idx   = wb_adr_i[7:2];
    assign req   = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr_lo = req & wb_we_i & wb_sel_i[0];
    assign ev_clr = (wr_lo && idx == `LFS_IDX_IRQ_STAT) ? wb_dat_i[2:0] : 3'h0;

    lfs_irq u_irq (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .event_in   (ev),
        .clear_in   (ev_clr),
        .mask_in    (irq_mask_r),
        .status_out (ev_stat),
        .irq_out    (irq)
    );

    always @* begin
        case (idx)
            `LFS_IDX_LINK_STAT:  rdata_nxt = {prbs_pass_flag_r, 3'h0, neg_fault_r, pos_fault_r};
            `LFS_IDX_RSVD_A:     rdata_nxt = `LFS_RST_RSVD_A;
            `LFS_IDX_RSVD_B:     rdata_nxt = `LFS_RST_RSVD_B;
            `LFS_IDX_RSVD_C:     rdata_nxt = `LFS_RST_RSVD_C;
            `LFS_IDX_RSVD_D:     rdata_nxt = `LFS_RST_RSVD_D;
            `LFS_IDX_RSVD_E:     rdata_nxt = `LFS_RST_RSVD_E;
            `LFS_IDX_RSVD_F:     rdata_nxt = `LFS_RST_RSVD_F;
            `LFS_IDX_RSVD_G:     rdata_nxt = `LFS_RST_RSVD_G;
            `LFS_IDX_RSVD_H:     rdata_nxt = `LFS_RST_RSVD_H;
            `LFS_IDX_PIN_LEVELS: rdata_nxt = {pin_lvl, 4'h0};
            `LFS_IDX_DEV_ID:     rdata_nxt = DEV_ID;
            `LFS_IDX_CAP_REV:    rdata_nxt = {3'h0, CAP_FLAG, REVISION};
            `LFS_IDX_IRQ_STAT:   rdata_nxt = {5'h0, ev_stat};
            `LFS_IDX_IRQ_MASK:   rdata_nxt = {5'h0, irq_mask_r};
            default:             rdata_nxt = 8'h00;
        endcase
    end

    // only the mask and the irq status (write-one-to-clear) take writes; every other index drops them
    always @(posedge sys_clk) begin
        if (rst) begin
            ack_r      <= 1'h0;
            rdata_r    <= 8'h00;
            irq_mask_r <= `LFS_RST_IRQ;
        end else begin
            ack_r   <= req;
            rdata_r <= req ? rdata_nxt : 8'h00;
            if (wr_lo && idx == `LFS_IDX_IRQ_MASK) begin
                irq_mask_r <= wb_dat_i[2:0];
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = {24'h000000, rdata_r};
endmodule

// [verif/lfs_status_regs_sva.sv]
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module lfs_status_regs_sva #(
    parameter [7:0] DEV_ID = 8'h5a
) (
    input wire        sys_clk,
    input wire        rst,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        prbs_done_ok,
    input wire [1:0]  neg_wire_fault_code,
    input wire [1:0]  pos_wire_fault_code
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // master holds address through the ack cycle
    wire       rd = wb_ack_o & ~wb_we_i;
    wire [5:0] ix = wb_adr_i[7:2];
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
    a_prbs_flag: assert property (rd && ix == 6'h14 |-> wb_dat_o[7] == $past(prbs_done_ok, 2))
        else $error("pass flag wrong");
    a_neg_code: assert property (rd && ix == 6'h14 |-> wb_dat_o[3:2] == $past(neg_wire_fault_code, 2))
        else $error("neg code wrong");
    a_pos_code: assert property (rd && ix == 6'h14 |-> wb_dat_o[1:0] == $past(pos_wire_fault_code, 2))
        else $error("pos code wrong");
    a_pin_low_zero: assert property (rd && ix == 6'h1d |-> wb_dat_o[3:0] == 4'h0) else $error("pin nibble");
    a_dev_id_fixed: assert property (rd && ix == 6'h1e |-> wb_dat_o == {24'h0, DEV_ID}) else $error("id");
    a_rsvd_zero: assert property (rd && (ix == 6'h1b || ix == 6'h1c) |-> wb_dat_o == 32'h0) else $error("rsvd");
    a_link_rsvd_bits: assert property (rd && ix == 6'h14 |-> wb_dat_o[6:4] == 3'h0)
        else $error("link status reserved bits set");
    a_cap_rsvd_bits: assert property (rd && ix == 6'h1f |-> wb_dat_o[7:5] == 3'h0)
        else $error("revision reserved bits set");
endmodule
bind lfs_status_regs lfs_status_regs_sva #(.DEV_ID(DEV_ID)) lfs_status_regs_sva_inst (.*);

// [verif/lfs_far_side_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// receiver, fault detector and pin model
// ----------------------------------------
module lfs_far_side_model (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire  [8:0] far_cfg,
    output logic       prbs_done_ok,
    output logic [1:0] neg_wire_fault_code,
    output logic [1:0] pos_wire_fault_code,
    output logic       cable_type_pin_level,
    output logic       coax_input_select_level,
    output logic       control_iface_select_level,
    output logic       local_ctrl_channel_enable_level
);
    always @(posedge sys_clk) begin
        if (rst) begin
            prbs_done_ok <= 1'b0;
            {neg_wire_fault_code, pos_wire_fault_code} <= 4'ha;
            {cable_type_pin_level, coax_input_select_level} <= 2'h0;
            {control_iface_select_level, local_ctrl_channel_enable_level} <= 2'h0;
        end else begin
            // pass is held until reset
            prbs_done_ok <= prbs_done_ok | far_cfg[8];
            {neg_wire_fault_code, pos_wire_fault_code} <= far_cfg[7:4];
            {cable_type_pin_level, coax_input_select_level} <= far_cfg[3:2];
            {control_iface_select_level, local_ctrl_channel_enable_level} <= far_cfg[1:0];
        end
    end
endmodule

// [verif/tb_lfs_status_regs.sv]
`timescale 1ns/1ps
// ----------------------------------------
// register bank bench
// ----------------------------------------
module tb_lfs_status_regs;
    logic        sys_clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0]  wb_adr_i = 8'h0;
    logic [3:0]  wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0, rdat;
    logic [8:0]  far_cfg = 9'h0a0;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o, irq, prbs_done_ok;
    wire  [1:0]  neg_wire_fault_code, pos_wire_fault_code;
    wire         cable_type_pin_level, coax_input_select_level;
    wire         control_iface_select_level, local_ctrl_channel_enable_level;
    int          error_cnt = 0, check_count = 0;
    logic [7:0]  rsv [8] = '{8'h20, 8'h30, 8'h54, 8'h30, 8'hc8, 8'h00, 8'h00, 8'h00};
    lfs_status_regs lfs_status_regs_inst (.*);
    lfs_far_side_model lfs_far_side_model_inst (.*);
    initial forever #4 sys_clk = ~sys_clk;
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    task end_sim;
        $display("errors=%0d checks=%0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        rchk(8'h50, 32'h0a);
        for (int c = 0; c < 4; c++) begin
            far_cfg[7:4] <= {c[1:0], 2'(3 - c)};
            repeat (4) @(posedge sys_clk);
            rchk(8'h50, {c[1:0], 2'(3 - c)});
        end
        far_cfg[8] <= 1'b1;
        far_cfg[3:0] <= 4'ha;
        repeat (8) @(posedge sys_clk);
        rchk(8'h50, 32'h8c);
        rchk(8'h74, 32'ha0);
        bus(1'b1, 8'h78, 32'hff);
        rchk(8'h78, 32'h5a);
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, 8'h54 + 8'(4 * i), 32'hff);
            rchk(8'h54 + 8'(4 * i), {24'h0, rsv[i]});
        end
        bus(1'b1, 8'h50, 32'hff);
        rchk(8'h50, 32'h8c);
        bus(1'b1, 8'h7c, 32'hff);
        rchk(8'h7c, 32'h01);
        rchk(8'hfc, 32'h0);
        rchk(8'h80, 32'h7);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, 8'h84, 32'h7);
        #1 chk({31'h0, irq}, 32'h1);
        bus(1'b1, 8'h80, 32'h7);
        #1 chk({31'h0, irq}, 32'h0);
        rchk(8'h80, 32'h0);
        end_sim;
    end
    // generous against roughly 130 cycles of traffic
    initial begin
        repeat (3000) @(posedge sys_clk);
        error_cnt++;
        end_sim;
    end
endmodule
